//--- common/arct_pkg.sv
// constants for the auto-reload/capture timer: register map, fields, counts
// assumes a 25 MHz peripheral clock and the plain register port of the top
//
// Functional notes
// - timer mode advances once per twelve clocks
// - counter mode counts high-then-low samples only
// - select bit zero gives auto-reload mode
// - up mode overflows at all ones, reloads
// - external edge reloads, sets event flag
// - flags cleared only by software or the updown toggle
// - external reload beats simultaneous count edge
// - updown, pin high: count up, reload value
// - updown, pin low: down to reload, all ones
// - updown: event flag toggles, no request
// - updown: control pin level picks count direction
// - capture needs select and external enable
// - capture mode overflows to zero, requests
// - capture edge copies count, sets flag
// - control pin edges from consecutive samples
// - increment first, then capture new value
// - software or hardware edge sets run
// - only software clears the run bit
// - starting edge flags only, later edges act
// - prescaler bypasses divide-by-twelve, two-power divide
// - write one clears flag, zero ignored
// - stopped timer still takes external edge actions
`default_nettype none
package arct_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    // register offsets
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] MODE_ADDR = 4'h1;
    localparam logic [3:0] CLEAR_ADDR = 4'h2;
    localparam logic [3:0] RELOAD_ADDR = 4'h3;
    localparam logic [3:0] COUNT_ADDR = 4'h4;
    // control register fields
    localparam int unsigned CTRL_CRS = 0;
    localparam int unsigned CTRL_CTS = 1;
    localparam int unsigned CTRL_RUN = 2;
    localparam int unsigned CTRL_EEE = 3;
    localparam int unsigned CTRL_EXF = 6;
    localparam int unsigned CTRL_OVF = 7;
    // mode register fields
    localparam int unsigned MODE_UDE = 0;
    localparam int unsigned MODE_PRE_LO = 1;
    localparam int unsigned MODE_PRE_HI = 3;
    localparam int unsigned MODE_PEN = 4;
    localparam int unsigned MODE_EDGE = 5;
    localparam int unsigned MODE_HSE = 6;
    localparam int unsigned MODE_HSEDGE = 7;
    // clear register fields
    localparam int unsigned CLR_EXF = 6;
    localparam int unsigned CLR_OVF = 7;
    // values and counts
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam int unsigned PRE_W = 7;
endpackage
`default_nettype wire

//--- hw/arct_timer.sv
// 16-bit auto-reload / capture timer with plain register port
// assumes count and control pins are synchronous to clock
`default_nettype none
module arct_timer (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // external pins
    input wire logic count_input_pin,
    input wire logic external_control_pin,
    // status and requests
    output logic overflow_flag,
    output logic external_event_flag,
    output logic overflow_request,
    output logic external_request
);
    // picks the rising or falling edge by a select bit
    function automatic logic arct_pick_edge(input logic sel,
        input logic rise, input logic fall);
        arct_pick_edge = sel ? rise : fall;
    endfunction

    logic [15:0] count_reg;
    logic [15:0] rc_reg;
    logic [15:0] rdata_reg;
    logic [15:0] count_step;
    logic run_reg;
    logic crs_reg;
    logic cts_reg;
    logic eee_reg;
    logic ude_reg;
    logic [2:0] pre_sel_reg;
    logic pen_reg;
    logic edge_sel_reg;
    logic hse_reg;
    logic hs_edge_reg;
    logic ovf_flag_reg;
    logic exf_flag_reg;
    logic ovf_req_reg;
    logic ext_req_reg;
    logic cnt_prev_reg;
    logic ext_prev_reg;
    logic [3:0] div12_reg;
    logic [6:0] pre_cnt_reg;
    logic [6:0] pre_mask;
    logic tick12;
    logic tick_pre;
    logic timer_tick;
    logic cnt_fall;
    logic ext_rise;
    logic ext_fall;
    logic sel_edge;
    logic start_edge;
    logic hw_start_now;
    logic capture_mode;
    logic updown;
    logic count_up;
    logic inc;
    logic ovf_evt;
    logic ext_action;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_clear;
    logic wr_rc;
    logic wr_count;

    // address decode of write strobes
    assign wr_ctrl = wr && (addr == arct_pkg::CTRL_ADDR);
    assign wr_mode = wr && (addr == arct_pkg::MODE_ADDR);
    assign wr_clear = wr && (addr == arct_pkg::CLEAR_ADDR);
    assign wr_rc = wr && (addr == arct_pkg::RELOAD_ADDR);
    assign wr_count = wr && (addr == arct_pkg::COUNT_ADDR);

    // pin edges from this sample against the previous one
    assign cnt_fall = cnt_prev_reg & ~count_input_pin;
    assign ext_rise = ~ext_prev_reg & external_control_pin;
    assign ext_fall = ext_prev_reg & ~external_control_pin;
    assign sel_edge = arct_pick_edge(edge_sel_reg, ext_rise, ext_fall);
    assign start_edge = arct_pick_edge(hs_edge_reg, ext_rise, ext_fall);

    // mode decode
    assign capture_mode = crs_reg & eee_reg;
    assign updown = ude_reg & ~crs_reg;
    assign count_up = ~updown | external_control_pin;

    // hardware start consumes its own edge
    assign hw_start_now = hse_reg & ~run_reg & start_edge;
    // stopped timers still act on edges, except the starting edge
    assign ext_action = eee_reg & sel_edge & ~hw_start_now & ~updown;

    // count clock selection
    assign tick12 = (div12_reg == arct_pkg::DIV12_LAST);
    assign pre_mask = 7'((8'h01 << pre_sel_reg) - 8'h01);
    assign tick_pre = ((pre_cnt_reg & pre_mask) == pre_mask);
    assign timer_tick = pen_reg ? tick_pre : tick12;
    assign inc = run_reg & (cts_reg ? cnt_fall : timer_tick);

    // overflow: all ones going up, reload value going down
    assign ovf_evt = inc & (count_up ? (count_reg == arct_pkg::COUNT_MAX)
                                     : (count_reg == rc_reg));

    // next count after an increment, used for capture too
    always_comb begin
        count_step = count_reg;
        if (inc) begin
            if (ovf_evt && !count_up) begin
                count_step = arct_pkg::COUNT_MAX;
            end else if (ovf_evt && capture_mode) begin
                count_step = arct_pkg::COUNT_ZERO;
            end else if (ovf_evt) begin
                count_step = rc_reg;
            end else if (count_up) begin
                count_step = count_reg + 16'h0001;
            end else begin
                count_step = count_reg - 16'h0001;
            end
        end
    end

    // pin sample history
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_prev_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            cnt_prev_reg <= count_input_pin;
            ext_prev_reg <= external_control_pin;
        end
    end

    // free-running dividers; a phase error of one period at start
    // is accepted to keep the dividers simple
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div12_reg <= 4'h0;
            pre_cnt_reg <= 7'h00;
        end else begin
            div12_reg <= tick12 ? 4'h0 : div12_reg + 4'h1;
            pre_cnt_reg <= pre_cnt_reg + 7'h01;
        end
    end

    // control and mode bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            crs_reg <= 1'b0;
            cts_reg <= 1'b0;
            eee_reg <= 1'b0;
            ude_reg <= 1'b0;
            pre_sel_reg <= 3'h0;
            pen_reg <= 1'b0;
            edge_sel_reg <= 1'b0;
            hse_reg <= 1'b0;
            hs_edge_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                crs_reg <= wdata[arct_pkg::CTRL_CRS];
                cts_reg <= wdata[arct_pkg::CTRL_CTS];
                eee_reg <= wdata[arct_pkg::CTRL_EEE];
            end
            if (wr_mode) begin
                ude_reg <= wdata[arct_pkg::MODE_UDE];
                pre_sel_reg <=
                    wdata[arct_pkg::MODE_PRE_HI:arct_pkg::MODE_PRE_LO];
                pen_reg <= wdata[arct_pkg::MODE_PEN];
                edge_sel_reg <= wdata[arct_pkg::MODE_EDGE];
                hse_reg <= wdata[arct_pkg::MODE_HSE];
                hs_edge_reg <= wdata[arct_pkg::MODE_HSEDGE];
            end
        end
    end

    // run bit: software write, hardware only ever sets it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_reg <= 1'b0;
        end else if (wr_ctrl) begin
            run_reg <= wdata[arct_pkg::CTRL_RUN];
        end else if (hw_start_now) begin
            run_reg <= 1'b1;
        end
    end

    // count register; software write has top priority
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= arct_pkg::RESET_VAL;
        end else if (wr_count) begin
            count_reg <= wdata;
        end else if (ext_action && !capture_mode) begin
            count_reg <= rc_reg;
        end else begin
            count_reg <= count_step;
        end
    end

    // reload/capture register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rc_reg <= arct_pkg::RESET_VAL;
        end else if (wr_rc) begin
            rc_reg <= wdata;
        end else if (ext_action && capture_mode) begin
            rc_reg <= count_step;
        end
    end

    // overflow flag; a set in the clear cycle wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovf_flag_reg <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag_reg <= 1'b1;
        end else if (wr_clear && wdata[arct_pkg::CLR_OVF]) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    // external event flag; toggles in updown mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            exf_flag_reg <= 1'b0;
        end else if (updown && ovf_evt) begin
            exf_flag_reg <= ~exf_flag_reg;
        end else if (ext_action || (hw_start_now && eee_reg)) begin
            exf_flag_reg <= 1'b1;
        end else if (wr_clear && wdata[arct_pkg::CLR_EXF]) begin
            exf_flag_reg <= 1'b0;
        end
    end

    // one-cycle request pulses
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovf_req_reg <= 1'b0;
            ext_req_reg <= 1'b0;
        end else begin
            ovf_req_reg <= ovf_evt;
            ext_req_reg <= ~updown & (ext_action
                           | (hw_start_now & eee_reg));
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else if (rd) begin
            case (addr)
                arct_pkg::CTRL_ADDR: rdata_reg <= {8'h00, ovf_flag_reg,
                    exf_flag_reg, 2'b00, eee_reg, run_reg, cts_reg,
                    crs_reg};
                arct_pkg::MODE_ADDR: rdata_reg <= {8'h00, hs_edge_reg,
                    hse_reg, edge_sel_reg, pen_reg, pre_sel_reg, ude_reg};
                arct_pkg::RELOAD_ADDR: rdata_reg <= rc_reg;
                arct_pkg::COUNT_ADDR: rdata_reg <= count_reg;
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata = rdata_reg;
    assign overflow_flag = ovf_flag_reg;
    assign external_event_flag = exf_flag_reg;
    assign overflow_request = ovf_req_reg;
    assign external_request = ext_req_reg;

    default clocking arct_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_div_twelve_rate: assert property (
        tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12
        ##1 tick12)
        else $error("timer tick not every twelve clocks");
    a_count_edge_inc: assert property (
        cts_reg && run_reg && cnt_fall && !ovf_evt && !updown
        && !ext_action && !wr_count
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter edge did not increment");
    a_reload_beats_count: assert property (
        ext_action && !capture_mode && inc && !wr_count
        |=> count_reg == $past(rc_reg))
        else $error("external reload lost to count edge");
    a_down_reload_ones: assert property (
        updown && !count_up && ovf_evt && !wr_count
        |=> count_reg == 16'hFFFF && ovf_flag_reg)
        else $error("underflow did not reload all ones");
    a_updown_toggle: assert property (
        updown && ovf_evt |=> exf_flag_reg != $past(exf_flag_reg)
        && !ext_req_reg)
        else $error("updown event flag did not toggle");
    a_capture_wrap: assert property (
        capture_mode && ovf_evt && !wr_count
        |=> count_reg == 16'h0000 && ovf_flag_reg)
        else $error("capture overflow did not wrap to zero");
    a_capture_value: assert property (
        ext_action && capture_mode && !wr_rc
        |=> rc_reg == $past(count_step) && exf_flag_reg)
        else $error("capture took wrong count");
    a_run_sticky: assert property (
        run_reg && !wr_ctrl |=> run_reg)
        else $error("run bit cleared by hardware");
    a_hw_start_run: assert property (
        hw_start_now && !wr_ctrl |=> run_reg)
        else $error("hardware start did not set run");
    a_flag_held: assert property (
        ovf_flag_reg && !(wr_clear && wdata[arct_pkg::CLR_OVF])
        |=> ovf_flag_reg)
        else $error("overflow flag dropped without clear");
endmodule // arct_timer
`default_nettype wire

//--- testbench/arct_pin_model.sv
// pin model: drives the count pin and the control pin of the timer
// assumes the bench calls its tasks between clock edges
`default_nettype none
module arct_pin_model (
    // clock
    input wire logic clock,
    // pins toward the timer
    output var logic count_input_pin,
    output var logic external_control_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // both pins idle high so the first low is a real falling transition
    initial begin
        count_input_pin = 1'b1;
        external_control_pin = 1'b1;
    end

    // each level stands one full clock, so no transition is missed
    task automatic count_pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock) count_input_pin <= 1'b0;
            @(posedge clock) count_input_pin <= 1'b1;
        end
    endtask

    // control level change, held one clock before returning
    task automatic set_ctrl(input logic v);
        @(posedge clock) external_control_pin <= v;
        @(posedge clock);
    endtask

    // count fall and control change in one cycle, for priority cases
    task automatic both(input logic v);
        @(posedge clock);
        count_input_pin <= 1'b0;
        external_control_pin <= v;
        @(posedge clock) count_input_pin <= 1'b1;
    endtask
endmodule // arct_pin_model
`default_nettype wire

//--- testbench/test_arct_timer.sv
// bench for the auto-reload/capture timer: register tasks, pin scenarios
// assumes the pin model drives both timer pins
`default_nettype none
module test_arct_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic cnt_pin;
    logic ctl_pin;
    logic ovf_flag;
    logic ext_flag;
    logic ovf_req;
    logic ext_req;
    int failures = 0;
    int checks = 0;
    int ovf_pulses = 0;
    int ext_pulses = 0;

    // 25 MHz clock
    always #20 clock = ~clock;

    arct_timer u_arct_timer (.clock(clock), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .count_input_pin(cnt_pin), .external_control_pin(ctl_pin),
        .overflow_flag(ovf_flag), .external_event_flag(ext_flag),
        .overflow_request(ovf_req), .external_request(ext_req));

    arct_pin_model u_arct_pin_model (.clock(clock),
        .count_input_pin(cnt_pin), .external_control_pin(ctl_pin));

    // requests are one-cycle pulses, so tally them on every edge
    always @(posedge clock) begin
        if (ovf_req === 1'b1)
            ovf_pulses++;
        if (ext_req === 1'b1)
            ext_pulses++;
    end

    task automatic check_word(input string name, input logic [15:0] exp,
                              input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp,
                             input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        read_reg(a, d);
        check_word("register_read", e, d);
    endtask

    // small delay lets the edge that changed the flags land first
    task automatic flags(input logic o, input logic x);
        #1;
        check_bit("overflow_flag", o, ovf_flag);
        check_bit("external_event_flag", x, ext_flag);
    endtask

    // count advance over exactly n clocks; divider phase cancels out
    task automatic measure(input int n, input logic [15:0] e);
        logic [15:0] a;
        logic [15:0] b;
        read_reg(arct_pkg::COUNT_ADDR, a);
        repeat (n - 2) @(posedge clock);
        read_reg(arct_pkg::COUNT_ADDR, b);
        check_word("count_step", e, b - a);
    endtask

    task automatic complete_run();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(40 * 5000);
        failures++;
        $display("MISMATCH watchdog expected done seen hang");
        complete_run();
    end

    // main sequence
    initial begin
        rst <= 1'b1;
        addr <= 4'h0;
        wdata <= 16'h0000;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(4'(i), 16'h0000);
        end
        // counter mode, up-only reload on overflow
        write_reg(arct_pkg::RELOAD_ADDR, 16'h1234);
        write_reg(arct_pkg::COUNT_ADDR, 16'hFFFE);
        write_reg(arct_pkg::CTRL_ADDR, 16'h0006);
        u_arct_pin_model.count_pulse(2);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h1234);
        flags(1'b1, 1'b0);
        check_word("overflow_pulses", 16'h0001, 16'(ovf_pulses));
        repeat (20) @(posedge clock);
        flags(1'b1, 1'b0);
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0000);
        flags(1'b1, 1'b0);
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0080);
        flags(1'b0, 1'b0);
        // external falling edge reload, then a rising edge ignored
        write_reg(arct_pkg::RELOAD_ADDR, 16'h0ABC);
        write_reg(arct_pkg::COUNT_ADDR, 16'h0010);
        write_reg(arct_pkg::CTRL_ADDR, 16'h000E);
        u_arct_pin_model.set_ctrl(1'b0);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0ABC);
        flags(1'b0, 1'b1);
        check_word("external_pulses", 16'h0001, 16'(ext_pulses));
        u_arct_pin_model.set_ctrl(1'b1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0ABC);
        // reload and count edge together: no increment
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0040);
        u_arct_pin_model.both(1'b0);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0ABC);
        flags(1'b0, 1'b1);
        u_arct_pin_model.set_ctrl(1'b1);
        u_arct_pin_model.count_pulse(1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0ABD);
        // capture mode on rising control edges
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0040);
        write_reg(arct_pkg::MODE_ADDR, 16'h0020);
        write_reg(arct_pkg::CTRL_ADDR, 16'h000F);
        write_reg(arct_pkg::COUNT_ADDR, 16'h0100);
        u_arct_pin_model.set_ctrl(1'b0);
        u_arct_pin_model.count_pulse(3);
        rd_chk(arct_pkg::RELOAD_ADDR, 16'h0ABC);
        flags(1'b0, 1'b0);
        u_arct_pin_model.set_ctrl(1'b1);
        rd_chk(arct_pkg::RELOAD_ADDR, 16'h0103);
        flags(1'b0, 1'b1);
        u_arct_pin_model.set_ctrl(1'b0);
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0040);
        u_arct_pin_model.both(1'b1);
        rd_chk(arct_pkg::RELOAD_ADDR, 16'h0104);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0104);
        check_word("external_pulses", 16'h0004, 16'(ext_pulses));
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0040);
        write_reg(arct_pkg::COUNT_ADDR, 16'hFFFF);
        u_arct_pin_model.count_pulse(1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0000);
        flags(1'b1, 1'b0);
        check_word("overflow_pulses", 16'h0002, 16'(ovf_pulses));
        // up/down counting steered by the control level
        write_reg(arct_pkg::CLEAR_ADDR, 16'h00C0);
        write_reg(arct_pkg::MODE_ADDR, 16'h0001);
        write_reg(arct_pkg::CTRL_ADDR, 16'h0006);
        write_reg(arct_pkg::COUNT_ADDR, 16'hFFFF);
        write_reg(arct_pkg::RELOAD_ADDR, 16'h0050);
        u_arct_pin_model.count_pulse(1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0050);
        flags(1'b1, 1'b1);
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0080);
        u_arct_pin_model.set_ctrl(1'b0);
        write_reg(arct_pkg::COUNT_ADDR, 16'h0052);
        u_arct_pin_model.count_pulse(1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0051);
        u_arct_pin_model.count_pulse(2);
        flags(1'b1, 1'b0);
        // the read lets the last request pulse reach the tally first
        rd_chk(arct_pkg::COUNT_ADDR, 16'hFFFF);
        check_word("overflow_pulses", 16'h0004, 16'(ovf_pulses));
        check_word("external_pulses", 16'h0004, 16'(ext_pulses));
        // timer mode rates: fixed divider, then prescale settings 2, 0 and 7
        write_reg(arct_pkg::MODE_ADDR, 16'h0000);
        write_reg(arct_pkg::CTRL_ADDR, 16'h0004);
        write_reg(arct_pkg::COUNT_ADDR, 16'h0000);
        measure(12, 16'h0001);
        write_reg(arct_pkg::MODE_ADDR, 16'h0014);
        measure(12, 16'h0003);
        write_reg(arct_pkg::MODE_ADDR, 16'h0010);
        measure(12, 16'h000C);
        write_reg(arct_pkg::MODE_ADDR, 16'h001E);
        measure(128, 16'h0001);
        write_reg(arct_pkg::CTRL_ADDR, 16'h0000);
        measure(24, 16'h0000);
        // stopped timer: dummy reload, then hardware start on rise
        write_reg(arct_pkg::CLEAR_ADDR, 16'h00C0);
        write_reg(arct_pkg::MODE_ADDR, 16'h0000);
        write_reg(arct_pkg::CTRL_ADDR, 16'h000A);
        write_reg(arct_pkg::COUNT_ADDR, 16'h0007);
        write_reg(arct_pkg::RELOAD_ADDR, 16'h0777);
        u_arct_pin_model.set_ctrl(1'b1);
        u_arct_pin_model.set_ctrl(1'b0);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0777);
        flags(1'b0, 1'b1);
        write_reg(arct_pkg::CLEAR_ADDR, 16'h0040);
        write_reg(arct_pkg::MODE_ADDR, 16'h00C0);
        u_arct_pin_model.set_ctrl(1'b1);
        rd_chk(arct_pkg::CTRL_ADDR, 16'h004E);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0777);
        u_arct_pin_model.count_pulse(1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h0778);
        // updown hardware start on a falling edge counts down
        write_reg(arct_pkg::CTRL_ADDR, 16'h0002);
        write_reg(arct_pkg::MODE_ADDR, 16'h0041);
        write_reg(arct_pkg::COUNT_ADDR, 16'h0010);
        write_reg(arct_pkg::RELOAD_ADDR, 16'h0000);
        u_arct_pin_model.set_ctrl(1'b0);
        u_arct_pin_model.count_pulse(1);
        rd_chk(arct_pkg::COUNT_ADDR, 16'h000F);
        complete_run();
    end
endmodule // test_arct_timer
`default_nettype wire
